// file: core/ext_bus_pkg.sv
// Operation
// - device drives address for its external accesses
// - bus master drives address to peer memory
// - outside master drives address; device receives it
// - 64-bit data bus in both directions
// - id pattern 00x enables pin keepers
// - four active-low bank selects from address
// - async mode: selects follow the address
// - sync mode: select drops after ack seen
// - device asserts read strobe per half read
// - outside reader strobes halves it reads
// - device asserts write strobe per half written
// - outside writer strobes halves it writes
// - only bus master drives the strobes
// - page output marks dram page crossing
// - page output only for bank 0
// - bus pins float when suspended; as slave only read data is driven
// - sample sync inputs, synchronise async ones
// - outside party holds ack low for waits
package ext_bus_pkg;
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 64;
  localparam int HALF_W  = 32;
  localparam int NBANK   = 4;
  localparam int SHIFT_W = 5;
  localparam logic [2:0] ID_KEEP_MASK = 3'h6;
  localparam logic [2:0] ID_KEEP_VAL  = 3'h0;
  // apb register offsets of the host end
  localparam logic [7:0] CMD_OFS  = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WLO_OFS  = 8'h08;
  localparam logic [7:0] WHI_OFS  = 8'h0c;
  localparam logic [7:0] RLO_OFS  = 8'h10;
  localparam logic [7:0] RHI_OFS  = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] WAIT_OFS = 8'h1c;
  localparam logic [7:0] ELO_OFS  = 8'h20;
  localparam logic [7:0] EHI_OFS  = 8'h24;
  localparam logic [7:0] CAPA_OFS = 8'h28;
  localparam logic [7:0] CLO_OFS  = 8'h2c;
  localparam logic [7:0] CHI_OFS  = 8'h30;
  // field positions
  localparam int CMD_GO    = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_LOW   = 2;
  localparam int CMD_HIGH  = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  // reset values and timing
  localparam logic [7:0] WAIT_RST = 8'h00;
  localparam logic [1:0] HOLD_CYC = 2'h2;
endpackage : ext_bus_pkg

// file: core/ext_bus_if.sv
interface ext_bus_if;
  import ext_bus_pkg::*;
  logic [ADDR_W-1:0] dev_addr, host_addr, keep_addr, addr;
  logic              dev_addr_oe, host_addr_oe, keep_en;
  logic [DATA_W-1:0] dev_data, host_data, keep_data, data;
  logic              dev_data_oe, host_data_oe;
  logic [1:0]        dev_rd_n, dev_wr_n, host_rd_n, host_wr_n;
  logic              dev_strb_oe, host_strb_oe;
  logic [1:0]        rd_n, wr_n;
  logic [NBANK-1:0]  bank_select_n;
  logic              sel_oe;
  logic              page, page_oe;
  logic              ack;
  logic              suspend_bus_tristate_n;
  logic              dev_master;

  // wire levels: driver first, keeper next, pull-up on strobes
  assign addr = dev_addr_oe  ? dev_addr  :
                host_addr_oe ? host_addr :
                keep_en      ? keep_addr : '0;
  assign data = dev_data_oe  ? dev_data  :
                host_data_oe ? host_data :
                keep_en      ? keep_data : '0;
  assign rd_n = dev_strb_oe  ? dev_rd_n  :
                host_strb_oe ? host_rd_n : 2'h3;
  assign wr_n = dev_strb_oe  ? dev_wr_n  :
                host_strb_oe ? host_wr_n : 2'h3;

  modport dsp (output dev_addr, dev_addr_oe, keep_addr, keep_en,
               output dev_data, dev_data_oe, keep_data,
               output dev_rd_n, dev_wr_n, dev_strb_oe,
               output bank_select_n, sel_oe, page, page_oe,
               input  addr, data, rd_n, wr_n, ack,
               input  suspend_bus_tristate_n, dev_master);
  modport host (output host_addr, host_addr_oe, host_data,
                output host_data_oe, host_rd_n, host_wr_n,
                output host_strb_oe, ack, suspend_bus_tristate_n,
                output dev_master,
                input  addr, data, rd_n, wr_n, bank_select_n,
                input  page);
endinterface : ext_bus_if

// file: core/bank_decode.sv
module bank_decode (
  input  wire logic [ext_bus_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ext_bus_pkg::SHIFT_W-1:0] size_log2,
  output logic      [ext_bus_pkg::NBANK-1:0]   sel_n,
  output logic                                 in_bank0
);
  import ext_bus_pkg::*;
  logic [ADDR_W-1:0] bank;

  // bank n spans n*2^size up to (n+1)*2^size
  always_comb begin
    bank     = addr >> size_log2;
    sel_n    = '1;
    in_bank0 = 1'b0;
    if (bank < ADDR_W'(NBANK)) begin
      sel_n[bank[1:0]] = 1'b0;
      in_bank0         = (bank == '0);
    end
  end
endmodule : bank_decode

// file: core/dsp_port.sv
// Implementation choices: the valid/ready request port and the address map.
module dsp_port #(
  parameter int MEM_DEPTH = 16
) (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  ext_bus_if.dsp                                 bus,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire logic                              req_write,
  input  wire logic [1:0]                        req_halves,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0]    req_addr,
  input  wire logic [ext_bus_pkg::DATA_W-1:0]    req_wdata,
  output logic                                   rsp_valid,
  output logic      [ext_bus_pkg::DATA_W-1:0]    rsp_rdata,
  input  wire logic                              sync_mode,
  input  wire logic [ext_bus_pkg::SHIFT_W-1:0]   bank_size_log2,
  input  wire logic [ext_bus_pkg::SHIFT_W-1:0]   page_size_log2,
  input  wire logic [2:0]                        processor_id_pins,
  output logic                                   suspended
);
  import ext_bus_pkg::*;
  localparam int IDX_W = $clog2(MEM_DEPTH);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } state_t;

  state_t            state_r, state_nxt;
  logic [2:0]        id_s1_r, id_s2_r;
  logic              susp_r;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic              write_r, write_nxt, rsp_r, rsp_nxt;
  logic [1:0]        halves_r, halves_nxt;
  logic [NBANK-1:0]  sel_n_r, sel_n_nxt, dec_sel_n;
  logic              dec_bank0;
  logic              page_r, page_nxt;
  logic [ADDR_W-1:0] last_pg_r, last_pg_nxt, req_pg;
  logic              pg_valid_r, pg_valid_nxt;
  logic              drive_en, take, done;
  logic [DATA_W-1:0] mem_r [MEM_DEPTH];
  logic [DATA_W-1:0] sl_data_r;
  logic              sl_oe_r;
  logic [IDX_W-1:0]  sl_idx;
  logic [ADDR_W-1:0] keep_addr_r;
  logic [DATA_W-1:0] keep_data_r;

  bank_decode u_dec (
    .addr      (req_addr),
    .size_log2 (bank_size_log2),
    .sel_n     (dec_sel_n),
    .in_bank0  (dec_bank0)
  );

  // strap and suspend sampling; id pins are async, two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      id_s1_r <= '0;
      id_s2_r <= '0;
      susp_r  <= 1'b0;
    end else begin
      id_s1_r <= processor_id_pins;
      id_s2_r <= id_s1_r;
      susp_r  <= ~bus.suspend_bus_tristate_n;
    end
  end

  // master-side pins float when slave or suspended
  assign drive_en  = bus.dev_master & ~susp_r;
  assign suspended = susp_r;
  assign req_ready = (state_r == ST_IDLE) && drive_en;
  assign take      = req_valid && req_ready;
  assign done      = (state_r == ST_ACCESS) && drive_en && bus.ack;
  assign req_pg    = req_addr >> page_size_log2;

  // master sequencer: hold access until ack, halt when suspended
  always_comb begin
    state_nxt    = state_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    write_nxt    = write_r;
    halves_nxt   = halves_r;
    sel_n_nxt    = sel_n_r;
    page_nxt     = page_r;
    last_pg_nxt  = last_pg_r;
    pg_valid_nxt = pg_valid_r;
    rdata_nxt    = rdata_r;
    rsp_nxt      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt  = ST_ACCESS;
          addr_nxt   = req_addr;
          wdata_nxt  = req_wdata;
          write_nxt  = req_write;
          halves_nxt = req_halves;
          sel_n_nxt  = dec_sel_n;
          page_nxt   = dec_bank0 &&
                       (!pg_valid_r || req_pg != last_pg_r);
          if (dec_bank0) begin
            last_pg_nxt  = req_pg;
            pg_valid_nxt = 1'b1;
          end
        end
      end
      ST_ACCESS: begin
        if (done) begin
          state_nxt = ST_IDLE;
          rsp_nxt   = 1'b1;
          page_nxt  = 1'b0;
          if (!write_r)
            rdata_nxt = bus.data;
          if (sync_mode)
            sel_n_nxt = '1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= ST_IDLE;
      addr_r     <= '0;
      wdata_r    <= '0;
      write_r    <= 1'b0;
      halves_r   <= '0;
      sel_n_r    <= '1;
      page_r     <= 1'b0;
      last_pg_r  <= '0;
      pg_valid_r <= 1'b0;
      rdata_r    <= '0;
      rsp_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      write_r    <= write_nxt;
      halves_r   <= halves_nxt;
      sel_n_r    <= sel_n_nxt;
      page_r     <= page_nxt;
      last_pg_r  <= last_pg_nxt;
      pg_valid_r <= pg_valid_nxt;
      rdata_r    <= rdata_nxt;
      rsp_r      <= rsp_nxt;
    end
  end

  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;

  // master-side pins; strobes low only for halves moved
  always_comb begin
    bus.dev_addr    = addr_r;
    bus.dev_addr_oe = drive_en;
    bus.dev_strb_oe = drive_en;
    bus.dev_rd_n    = '1;
    bus.dev_wr_n    = '1;
    if (state_r == ST_ACCESS) begin
      if (write_r)
        bus.dev_wr_n = ~halves_r;
      else
        bus.dev_rd_n = ~halves_r;
    end
    bus.bank_select_n = sel_n_r;
    bus.sel_oe        = drive_en;
    bus.page          = page_r;
    bus.page_oe       = drive_en;
    bus.dev_data      = drive_en ? wdata_r : sl_data_r;
    bus.dev_data_oe   = (drive_en && write_r &&
                         state_r == ST_ACCESS) ||
                        (sl_oe_r && !susp_r);
  end

  // slave side: outside master strobes internal memory halves
  assign sl_idx = bus.addr[IDX_W-1:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sl_data_r <= '0;
      sl_oe_r   <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++)
        mem_r[i] <= '0;
    end else begin
      sl_oe_r   <= !bus.dev_master && (bus.rd_n != 2'h3);
      sl_data_r <= mem_r[sl_idx];
      if (!bus.dev_master) begin
        if (!bus.wr_n[0])
          mem_r[sl_idx][HALF_W-1:0] <= bus.data[HALF_W-1:0];
        if (!bus.wr_n[1])
          mem_r[sl_idx][DATA_W-1:HALF_W] <=
            bus.data[DATA_W-1:HALF_W];
      end
    end
  end

  // keepers hold last seen bus level for id pattern 00x
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keep_addr_r <= '0;
      keep_data_r <= '0;
    end else begin
      keep_addr_r <= bus.addr;
      keep_data_r <= bus.data;
    end
  end

  assign bus.keep_en   = (id_s2_r & ID_KEEP_MASK) == ID_KEEP_VAL;
  assign bus.keep_addr = keep_addr_r;
  assign bus.keep_data = keep_data_r;
endmodule : dsp_port

// file: core/host_port.sv
module host_port (
  input  wire logic        clk,
  input  wire logic        resetn,
  ext_bus_if.host          bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        suspend_req
);
  import ext_bus_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_GRAB = 3'b010,
    H_XFER = 3'b100
  } hstate_t;

  hstate_t           st_r, st_nxt;
  logic [3:0]        cmd_r, cmd_nxt;
  logic [31:0]       addr_r, addr_nxt, capa_r, capa_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [DATA_W-1:0] ext_r, ext_nxt, cap_r, cap_nxt;
  logic [7:0]        wait_r, wait_nxt, wcnt_r, wcnt_nxt;
  logic [1:0]        hold_r, hold_nxt;
  logic              done_r, done_nxt, wr_acc;
  logic              dev_rd, dev_wr, dev_act;

  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign dev_rd  = (st_r == H_IDLE) && (bus.rd_n != 2'h3);
  assign dev_wr  = (st_r == H_IDLE) && (bus.wr_n != 2'h3);
  assign dev_act = dev_rd || dev_wr;

  // registers, command sequencer and wait-state responder
  always_comb begin
    st_nxt   = st_r;
    cmd_nxt  = cmd_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    ext_nxt  = ext_r;
    cap_nxt  = cap_r;
    capa_nxt = capa_r;
    wait_nxt = wait_r;
    hold_nxt = hold_r;
    done_nxt = done_r;
    wcnt_nxt = dev_act && wcnt_r != wait_r ? wcnt_r + 8'h01 :
               dev_act ? wcnt_r : 8'h00;
    if (wr_acc) begin
      case (paddr)
        ADDR_OFS: addr_nxt = pwdata;
        WLO_OFS:  wd_nxt[HALF_W-1:0] = pwdata;
        WHI_OFS:  wd_nxt[DATA_W-1:HALF_W] = pwdata;
        WAIT_OFS: wait_nxt = pwdata[7:0];
        ELO_OFS:  ext_nxt[HALF_W-1:0] = pwdata;
        EHI_OFS:  ext_nxt[DATA_W-1:HALF_W] = pwdata;
        STAT_OFS: if (pwdata[STAT_DONE]) done_nxt = 1'b0;
        CMD_OFS:  if (st_r == H_IDLE && pwdata[CMD_GO]) begin
          cmd_nxt = pwdata[3:0];
          st_nxt  = H_GRAB;
        end
        default: ;
      endcase
    end
    // capture only the halves whose write strobe is low
    if (bus.ack && dev_wr) begin
      capa_nxt = bus.addr;
      if (!bus.wr_n[0])
        cap_nxt[HALF_W-1:0] = bus.data[HALF_W-1:0];
      if (!bus.wr_n[1])
        cap_nxt[DATA_W-1:HALF_W] = bus.data[DATA_W-1:HALF_W];
    end
    case (st_r)
      H_IDLE: ;
      H_GRAB: begin
        hold_nxt = HOLD_CYC;
        if (bus.rd_n == 2'h3 && bus.wr_n == 2'h3)
          st_nxt = H_XFER;
      end
      H_XFER: begin
        hold_nxt = hold_r - 2'h1;
        if (hold_r == 2'h1) begin
          st_nxt   = H_IDLE;
          done_nxt = 1'b1;                     // set beats clear
          if (!cmd_r[CMD_WRITE])
            rd_nxt = bus.data;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r   <= H_IDLE;
      cmd_r  <= '0;
      addr_r <= '0;
      wd_r   <= '0;
      rd_r   <= '0;
      ext_r  <= '0;
      cap_r  <= '0;
      capa_r <= '0;
      wait_r <= WAIT_RST;
      wcnt_r <= '0;
      hold_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cmd_r  <= cmd_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      ext_r  <= ext_nxt;
      cap_r  <= cap_nxt;
      capa_r <= capa_nxt;
      wait_r <= wait_nxt;
      wcnt_r <= wcnt_nxt;
      hold_r <= hold_nxt;
      done_r <= done_nxt;
    end
  end

  // apb read mux
  always_comb begin
    case (paddr)
      CMD_OFS:  prdata = {28'h0, cmd_r};
      ADDR_OFS: prdata = addr_r;
      WLO_OFS:  prdata = wd_r[HALF_W-1:0];
      WHI_OFS:  prdata = wd_r[DATA_W-1:HALF_W];
      RLO_OFS:  prdata = rd_r[HALF_W-1:0];
      RHI_OFS:  prdata = rd_r[DATA_W-1:HALF_W];
      STAT_OFS: prdata = {30'h0, done_r, st_r != H_IDLE};
      WAIT_OFS: prdata = {24'h0, wait_r};
      ELO_OFS:  prdata = ext_r[HALF_W-1:0];
      EHI_OFS:  prdata = ext_r[DATA_W-1:HALF_W];
      CAPA_OFS: prdata = capa_r;
      CLO_OFS:  prdata = cap_r[HALF_W-1:0];
      CHI_OFS:  prdata = cap_r[DATA_W-1:HALF_W];
      default:  prdata = 32'h0;
    endcase
  end

  // bus pins: host takes the bus while a command runs
  assign bus.dev_master   = (st_r == H_IDLE);
  assign bus.host_addr    = addr_r;
  assign bus.host_addr_oe = (st_r == H_XFER);
  assign bus.host_strb_oe = (st_r == H_XFER);
  assign bus.host_rd_n    = (st_r == H_XFER && !cmd_r[CMD_WRITE]) ?
                            ~cmd_r[CMD_HIGH:CMD_LOW] : 2'h3;
  assign bus.host_wr_n    = (st_r == H_XFER && cmd_r[CMD_WRITE]) ?
                            ~cmd_r[CMD_HIGH:CMD_LOW] : 2'h3;
  assign bus.host_data    = (st_r == H_XFER) ? wd_r : ext_r;
  assign bus.host_data_oe = (st_r == H_XFER && cmd_r[CMD_WRITE]) ||
                            dev_rd;
  assign bus.ack          = !dev_act || wcnt_r == wait_r;
  assign bus.suspend_bus_tristate_n = ~suspend_req;
endmodule : host_port

// file: testbench/ext_bus_checker.sv
module ext_bus_checker #(
  parameter int BANK_SHIFT = 8
) (
  input wire logic                             clk,
  input wire logic                             resetn,
  input wire logic                             sync_mode,
  input wire logic [ext_bus_pkg::ADDR_W-1:0]   dev_addr,
  input wire logic                             dev_addr_oe,
  input wire logic                             host_addr_oe,
  input wire logic                             dev_data_oe,
  input wire logic                             dev_strb_oe,
  input wire logic                             host_strb_oe,
  input wire logic [1:0]                       rd_n,
  input wire logic [1:0]                       wr_n,
  input wire logic [ext_bus_pkg::NBANK-1:0]    bank_select_n,
  input wire logic                             sel_oe,
  input wire logic                             page,
  input wire logic                             page_oe,
  input wire logic                             ack,
  input wire logic                             suspend_bus_tristate_n,
  input wire logic                             dev_master
);
  timeunit 1ns;
  timeprecision 1ps;
  import ext_bus_pkg::*;

  logic [ADDR_W-1:0] bank_idx;
  logic [NBANK-1:0]  exp_sel;

  // select pattern expected for the address the device drives
  always_comb begin
    bank_idx = dev_addr >> BANK_SHIFT;
    exp_sel  = (bank_idx < NBANK) ? ~(4'h1 << bank_idx[1:0]) : 4'hf;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // device owns the bus and has a strobe low
  sequence dev_acc;
    dev_strb_oe && (rd_n != 2'h3 || wr_n != 2'h3);
  endsequence

  sequence acc_done;
    dev_acc ##0 ack;
  endsequence

  strobe_owner_a: assert property (!(dev_strb_oe && host_strb_oe))
    else $error("two drivers on the strobes");
  addr_owner_a: assert property (!(dev_addr_oe && host_addr_oe))
    else $error("two drivers on the address");
  sel_decode_a: assert property (dev_acc ##0 sel_oe |->
    bank_select_n == exp_sel)
    else $error("bank select does not match address");
  async_step_a: assert property (!sync_mode && sel_oe &&
    $past(sel_oe) && $changed(bank_select_n) |-> $changed(dev_addr))
    else $error("select moved without the address");
  sync_drop_a: assert property (sync_mode ##0 acc_done |=>
    bank_select_n == 4'hf)
    else $error("sync select held after ack");
  strobe_done_a: assert property (acc_done |=>
    rd_n == 2'h3 && wr_n == 2'h3)
    else $error("strobe held after ack");
  wait_hold_a: assert property (dev_acc ##0 !ack |=>
    !dev_strb_oe || ($stable(rd_n) && $stable(wr_n)))
    else $error("access ended while ack low");
  strobe_excl_a: assert property ((rd_n | wr_n) == 2'h3)
    else $error("read and write strobe low together");
  suspend_float_a: assert property (!suspend_bus_tristate_n &&
    !$past(suspend_bus_tristate_n) |-> !dev_addr_oe && !dev_data_oe &&
    !dev_strb_oe && !sel_oe && !page_oe)
    else $error("device drives while suspended");
  // as slave only read data for a strobe seen last cycle may be driven
  slave_float_a: assert property (!dev_master && !$past(dev_master) |->
    !dev_addr_oe && !dev_strb_oe &&
    (!dev_data_oe || $past(rd_n) != 2'h3))
    else $error("device drives while slave");
  page_bank0_a: assert property (page_oe && page |-> bank_idx == 0)
    else $error("page flag outside bank 0");
endmodule : ext_bus_checker

// file: testbench/external_bus_port_pins_test.sv
module external_bus_port_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_bus_pkg::*;

  logic        clk, resetn, req_valid, req_ready, req_write, rsp_valid;
  logic        sync_mode, suspended, psel, penable, pwrite, pready;
  logic        pslverr, suspend_req, last_page;
  logic [1:0]  req_halves;
  logic [31:0] req_addr, pwdata, prdata, rd;
  logic [63:0] req_wdata, rsp_rdata;
  logic [4:0]  bank_size_log2, page_size_log2;
  logic [2:0]  processor_id_pins;
  logic [7:0]  paddr;
  logic [3:0]  last_sel;
  int          bad_count, checked, lat;
  logic [31:0] pa [5] = '{32'h14, 32'h18, 32'h24, 32'h200, 32'h500};
  logic [3:0]  ps [5] = '{4'he, 4'he, 4'he, 4'hb, 4'hf};
  logic        pe [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  ext_bus_if bus ();
  dsp_port #(.MEM_DEPTH(16)) dsp_port_i (.clk(clk), .resetn(resetn),
    .bus(bus), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_halves(req_halves), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .sync_mode(sync_mode), .bank_size_log2(bank_size_log2),
    .page_size_log2(page_size_log2),
    .processor_id_pins(processor_id_pins), .suspended(suspended));
  host_port host_port_i (.clk(clk), .resetn(resetn), .bus(bus),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .suspend_req(suspend_req));
  ext_bus_checker #(.BANK_SHIFT(8)) ext_bus_checker_i (.clk(clk),
    .resetn(resetn), .sync_mode(sync_mode), .dev_addr(bus.dev_addr),
    .dev_addr_oe(bus.dev_addr_oe), .host_addr_oe(bus.host_addr_oe),
    .dev_data_oe(bus.dev_data_oe), .dev_strb_oe(bus.dev_strb_oe),
    .host_strb_oe(bus.host_strb_oe), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .bank_select_n(bus.bank_select_n), .sel_oe(bus.sel_oe),
    .page(bus.page), .page_oe(bus.page_oe), .ack(bus.ack),
    .suspend_bus_tristate_n(bus.suspend_bus_tristate_n),
    .dev_master(bus.dev_master));

  // free-running clock, 4 ns period
  always #2 clk = ~clk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [63:0] exp, got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // a bound that ran out ends the run
  task automatic tmo(input int n, input string nm);
    if (n >= 200) begin
      bad_count++;
      $display("[FAIL] %s expected handshake seen timeout", nm);
      results();
    end
  endtask : tmo

  // one apb transfer: setup, access until pready, one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    logic ok;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // pready and prdata are read mid-cycle, settled before the edge
    do begin
      @(negedge clk);
      ok = pready;
      q = prdata;
      @(posedge clk);
      n++;
    end while (ok !== 1'b1 && n < 200);
    psel <= 1'b0;
    penable <= 1'b0;
    tmo(n, "pready");
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0, rd);
    chk(nm, {32'h0, e}, {32'h0, rd});
  endtask : rdc

  // device access; select and page are caught in the first access cycle
  task automatic dev_op(input logic w, input logic [1:0] h,
                        input logic [31:0] a, input logic [63:0] d);
    int n;
    logic ok;
    req_valid <= 1'b1;
    req_write <= w;
    req_halves <= h;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    // ready and response are read mid-cycle, away from the launching edge
    do begin
      @(negedge clk);
      ok = req_ready;
      @(posedge clk);
      n++;
    end while (ok !== 1'b1 && n < 200);
    tmo(n, "req_ready");
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
      if (lat == 1) begin
        last_sel = bus.bank_select_n;
        last_page = bus.page;
      end
      ok = rsp_valid;
      @(posedge clk);
    end while (ok !== 1'b1 && lat < 200);
    tmo(lat, "rsp_valid");
  endtask : dev_op

  // host command into device memory, then wait for done and clear it
  task automatic host_op(input logic [3:0] cmd, input logic [31:0] a,
                         input logic [63:0] d);
    int n;
    wr(ADDR_OFS, a);
    wr(WLO_OFS, d[31:0]);
    wr(WHI_OFS, d[63:32]);
    wr(CMD_OFS, {28'h0, cmd});
    n = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0, rd);
      n++;
    end while (rd[STAT_DONE] !== 1'b1 && n < 200);
    tmo(n, "done");
    wr(STAT_OFS, 32'h2);
  endtask : host_op

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {req_valid, req_write, sync_mode, psel, penable, pwrite} = '0;
    suspend_req = 1'b0;
    req_halves = 2'h0;
    req_addr = 32'h0;
    req_wdata = 64'h0;
    bank_size_log2 = 5'h8;
    page_size_log2 = 5'h4;
    processor_id_pins = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("strb_idle", 64'hf, {60'h0, bus.rd_n, bus.wr_n});
    // device reads both halves from bank 1
    wr(ELO_OFS, 32'h1234_5678);
    wr(EHI_OFS, 32'h9abc_def0);
    dev_op(1'b0, 2'h3, 32'h104, 64'h0);
    chk("rdata", 64'h9abc_def0_1234_5678, rsp_rdata);
    chk("sel_bank1", 64'hd, {60'h0, last_sel});
    chk("sel_keep", 64'hd, {60'h0, bus.bank_select_n});
    chk("lat_nowait", 64'h2, 64'(lat));
    // device writes both halves, then the low half only, then the high half only
    dev_op(1'b1, 2'h3, 32'h310, 64'h0bad_cafe_1357_9bdf);
    chk("sel_bank3", 64'h7, {60'h0, last_sel});
    rdc(CAPA_OFS, 32'h310, "cap_addr");
    rdc(CLO_OFS, 32'h1357_9bdf, "cap_lo");
    rdc(CHI_OFS, 32'h0bad_cafe, "cap_hi");
    dev_op(1'b1, 2'h1, 32'h314, 64'h5555_aaaa_2468_ace0);
    rdc(CLO_OFS, 32'h2468_ace0, "cap_lo_only");
    rdc(CHI_OFS, 32'h0bad_cafe, "cap_hi_kept");
    dev_op(1'b1, 2'h2, 32'h318, 64'h7777_8888_9999_aaaa);
    rdc(CHI_OFS, 32'h7777_8888, "cap_hi_only");
    rdc(CLO_OFS, 32'h2468_ace0, "cap_lo_kept");
    // bank map, page crossings in bank 0, and other banks
    for (int i = 0; i < 5; i++) begin
      dev_op(1'b0, 2'h1, pa[i], 64'h0);
      chk("sel_map", {60'h0, ps[i]}, {60'h0, last_sel});
      chk("rd_low", 64'h1234_5678, {32'h0, rsp_rdata[31:0]});
      if (i > 0)
        chk("page", {63'h0, pe[i]}, {63'h0, last_page});
    end
    // synchronous mode with three wait cycles
    wr(WAIT_OFS, 32'h3);
    sync_mode <= 1'b1;
    dev_op(1'b0, 2'h3, 32'h104, 64'h0);
    chk("lat_wait", 64'h5, 64'(lat));
    chk("rdata_wait", 64'h9abc_def0_1234_5678, rsp_rdata);
    chk("sel_drop", 64'hf, {60'h0, bus.bank_select_n});
    wr(WAIT_OFS, 32'h0);
    // suspend floats the pins; keeper holds the address
    suspend_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk("susp_flag", 64'h1, {63'h0, suspended});
    chk("addr_float", 64'h0, {63'h0, bus.dev_addr_oe});
    chk("ready_susp", 64'h0, {63'h0, req_ready});
    chk("keep_addr", 64'h104, {32'h0, bus.addr});
    processor_id_pins <= 3'h2;
    repeat (4) @(posedge clk);
    chk("keep_off", 64'h0, {32'h0, bus.addr});
    processor_id_pins <= 3'h1;
    suspend_req <= 1'b0;
    repeat (4) @(posedge clk);
    chk("addr_drive", 64'h1, {63'h0, bus.dev_addr_oe});
    // host writes device memory, then one half only, and reads it back
    host_op(4'hf, 32'h5, 64'hfeed_0001_c0de_0002);
    host_op(4'h7, 32'h5, 64'h0000_0000_7777_0003);
    host_op(4'hd, 32'h5, 64'h0);
    rdc(RLO_OFS, 32'h7777_0003, "host_lo");
    rdc(RHI_OFS, 32'hfeed_0001, "host_hi");
    results();
  end
endmodule : external_bus_port_pins_test
